// ---- logic/rmsrx_pkg.sv ----
// Register map, field positions, reset values, timing counts and state type
// of the radio mode sequencer. Assumes a single 50 MHz digital clock.
// Summary of operation
// - Finished correction is subtracted from carrier frequency
// - Auto mode launches correction on receiver enable
// - Manual mode: host start bit launches correction
// - Auto-clear drops old correction before each auto-mode run
// - Correction bandwidth applies while correction runs
// - Low-index mode adds offset field times 488 Hz
// - Low-index startup uses two measure and relock passes
// - Temperature measurement only from standby or synthesizer
// - Temperature code rises one per degree drop
// - Temperature running flag clears within 100 us
// - Timeout if no threshold flag within start limit
// - Timeout after threshold limit once flag rose
// - Mode field decodes sleep, standby, synth, transmit, receive
// - Listen enable overrides the mode field
// - Ordered wake-up unless sequencer disable is set
// - Sleep to transmit passes standby, synthesizer, lock
// - Transmit: amplifier regulator, ramp, then bit clock
// - Synthesizer lock shown high on a pin
// - Error measurement spans four bit periods, signed
// - Mode-ready and transmit-ready indications to host
package rmsrx_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int AW = 6;

  localparam logic [5:0] OFS_OPMODE = 6'h00;
  localparam logic [5:0] OFS_AFC = 6'h04;
  localparam logic [5:0] OFS_LOWOFS = 6'h08;
  localparam logic [5:0] OFS_FRF = 6'h0C;
  localparam logic [5:0] OFS_AFCVAL = 6'h10;
  localparam logic [5:0] OFS_FEI = 6'h14;
  localparam logic [5:0] OFS_TEMP = 6'h18;
  localparam logic [5:0] OFS_TIMEOUT = 6'h1C;
  localparam logic [5:0] OFS_BW = 6'h20;
  localparam logic [5:0] OFS_BITDIV = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h28;

  localparam int OP_MODE_LSB = 0;
  localparam int OP_SEQDIS = 3;
  localparam int OP_LISTEN = 4;
  localparam int AFC_AUTO = 0;
  localparam int AFC_CLR = 1;
  localparam int AFC_LOWIX = 2;
  localparam int AFC_START = 3;
  localparam int AFC_BUSY = 4;
  localparam int TEMP_START = 0;
  localparam int TEMP_RUN = 1;
  localparam int TEMP_VAL_LSB = 8;
  localparam int TO_START_LSB = 0;
  localparam int TO_THR_LSB = 8;
  localparam int BW_RX_LSB = 0;
  localparam int BW_AFC_LSB = 8;
  localparam int ST_MODE_RDY = 0;
  localparam int ST_TX_RDY = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_LOCK = 3;
  localparam int ST_STATE_LSB = 8;

  localparam logic [2:0] MODE_RST = 3'h1;
  localparam logic [15:0] BITDIV_RST = 16'h28B1;
  localparam logic [7:0] BW_RX_RST = 8'h55;
  localparam logic [7:0] BW_AFC_RST = 8'h8B;
  localparam logic [23:0] FRF_RST = 24'h000000;
  localparam logic [7:0] TEMP_ZERO = 8'h80;

  localparam int TEMP_MAX_US = 100;
  localparam int TEMP_MAX_CYC = TEMP_MAX_US * (CLK_HZ / 1_000_000);
  localparam int FEI_BITS = 4;
  localparam int LOW_IDX_HZ = 488;
  localparam int FSTEP_HZ = 61;

  localparam int EN_W = 7;
  localparam int EN_XO = 0;
  localparam int EN_SYN = 1;
  localparam int EN_PAREG = 2;
  localparam int EN_RAMP = 3;
  localparam int EN_TX = 4;
  localparam int EN_RX = 5;
  localparam int EN_LST = 6;

  localparam int SY_N = 5;
  localparam int SY_XO = 0;
  localparam int SY_PLL = 1;
  localparam int SY_PAREG = 2;
  localparam int SY_RAMP = 3;
  localparam int SY_RSSI = 4;

  typedef enum logic [3:0] {
    S_SLEEP, S_STBY, S_FS, S_TXREG, S_TXRAMP, S_TX, S_RX, S_LISTEN
  } rmsrx_seq_e;
endpackage

// ---- logic/rmsrx_top.sv ----
// Mode sequencer with frequency correction, temperature and receive timeout.
// Assumes analog status pins are asynchronous; measurement results are on sys_clk.
module rmsrx_top #(
  parameter int TEMP_CYC = rmsrx_pkg::TEMP_MAX_CYC,
  parameter int FW = 24
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic [rmsrx_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Analog status pins
  input wire logic xo_ready_pin,
  input wire logic pll_lock_pin,
  input wire logic pa_reg_ready_pin,
  input wire logic pa_ramp_done_pin,
  input wire logic signal_threshold_flag,
  // Measurement results
  input wire logic [15:0] measured_freq_error,
  input wire logic temp_done_in,
  input wire logic [7:0] temp_celsius_in,
  // Block enables
  output logic xo_en,
  output logic synth_en,
  output logic pa_reg_en,
  output logic pa_ramp_en,
  output logic tx_en,
  output logic rx_en,
  output logic listen_active,
  output logic temp_adc_en,
  output logic fei_start,
  // Indications and data
  output logic bit_clock_output,
  output logic pll_lock_out,
  output logic mode_ready_irq,
  output logic transmit_ready_irq,
  output logic timeout_irq,
  output logic [7:0] rx_bw_sel,
  output logic [FW-1:0] frf_out
);
  import rmsrx_pkg::*;

  localparam int TW = $clog2(TEMP_CYC + 1);

  typedef struct packed {
    rmsrx_seq_e st;
    logic [2:0] mode;
    logic seq_dis;
    logic listen;
    logic auto_on;
    logic auto_clr;
    logic lowix;
    logic [7:0] lowofs;
    logic [FW-1:0] frf;
    logic [15:0] afcval;
    logic [15:0] freq_error_indicator;
    logic [7:0] to_start;
    logic [7:0] to_thr;
    logic [7:0] bw_rx;
    logic [7:0] bw_afc;
    logic [7:0] bw_sel;
    logic [7:0] temp_val;
    logic [15:0] bitdiv;
    logic [15:0] bitcnt;
    logic bclk;
    logic [SY_N-1:0] sync1;
    logic [SY_N-1:0] sync2;
    logic afc_busy;
    logic [2:0] afc_bits;
    logic afc_pass;
    logic afc_relock;
    logic fei_go;
    logic temp_run;
    logic [TW-1:0] temp_cnt;
    logic rssi_seen;
    logic [3:0] sub16;
    logic [7:0] units;
    logic to_flag;
    logic [EN_W-1:0] en;
    logic [31:0] rdata;
  } rmsrx_state_s;

  localparam rmsrx_state_s RST = '{st: S_SLEEP, mode: MODE_RST, frf: FRF_RST[FW-1:0],
    bw_rx: BW_RX_RST, bw_afc: BW_AFC_RST, bw_sel: BW_RX_RST, bitdiv: BITDIV_RST, default: '0};

  rmsrx_state_s r;
  rmsrx_state_s n;
  rmsrx_seq_e tgt;
  rmsrx_seq_e fall;
  logic [SY_N-1:0] pins;
  logic tick;
  logic afc_cmd;
  logic [15:0] ofs_steps;
  logic [15:0] corr;
  logic [7:0] lim;
  logic [31:0] rd;

  function automatic rmsrx_seq_e mode_state(input logic [2:0] m);
    case (m)
      3'h0: mode_state = S_SLEEP;
      3'h2: mode_state = S_FS;
      3'h3: mode_state = S_TX;
      3'h4: mode_state = S_RX;
      default: mode_state = S_STBY;
    endcase
  endfunction

  function automatic logic [EN_W-1:0] en_of(input rmsrx_seq_e s);
    en_of = {EN_W{1'b0}};
    en_of[EN_XO] = (s != S_SLEEP);
    en_of[EN_SYN] = s inside {S_FS, S_TXREG, S_TXRAMP, S_TX, S_RX};
    en_of[EN_PAREG] = s inside {S_TXREG, S_TXRAMP, S_TX};
    en_of[EN_RAMP] = s inside {S_TXRAMP, S_TX};
    en_of[EN_TX] = (s == S_TX);
    en_of[EN_RX] = (s == S_RX);
    en_of[EN_LST] = (s == S_LISTEN);
  endfunction

  assign pins = {signal_threshold_flag, pa_ramp_done_pin, pa_reg_ready_pin, pll_lock_pin, xo_ready_pin};
  assign tgt = r.listen ? S_LISTEN : mode_state(r.mode);
  assign fall = (tgt == S_TX || tgt == S_RX) ? S_FS : tgt;
  // Greater-or-equal so that a smaller divider written mid-period cannot stall the tick until wrap
  assign tick = (r.bitcnt >= r.bitdiv - 16'h0001);
  assign afc_cmd = reg_wr && (reg_addr == OFS_AFC) && reg_wdata[AFC_START];
  assign ofs_steps = 16'((32'(r.lowofs) * LOW_IDX_HZ) / FSTEP_HZ);
  assign corr = measured_freq_error + ((r.lowix && !r.afc_pass) ? ofs_steps : 16'h0000);
  assign lim = r.rssi_seen ? r.to_thr : r.to_start;

  always_comb begin
    n = r;
    n.fei_go = 1'b0;
    n.sync1 = pins;
    n.sync2 = r.sync1;
    n.bitcnt = tick ? 16'h0000 : r.bitcnt + 16'h0001;
    n.rdata = reg_rd ? rd : 32'h00000000;
    if (reg_wr) begin
      case (reg_addr)
        OFS_OPMODE: begin
          n.mode = reg_wdata[OP_MODE_LSB +: 3];
          n.seq_dis = reg_wdata[OP_SEQDIS];
          n.listen = reg_wdata[OP_LISTEN];
        end
        OFS_AFC: begin
          n.auto_on = reg_wdata[AFC_AUTO];
          n.auto_clr = reg_wdata[AFC_CLR];
          n.lowix = reg_wdata[AFC_LOWIX];
        end
        OFS_LOWOFS: n.lowofs = reg_wdata[7:0];
        OFS_FRF: n.frf = reg_wdata[FW-1:0];
        OFS_TIMEOUT: begin
          n.to_start = reg_wdata[TO_START_LSB +: 8];
          n.to_thr = reg_wdata[TO_THR_LSB +: 8];
        end
        OFS_BW: begin
          n.bw_rx = reg_wdata[BW_RX_LSB +: 8];
          n.bw_afc = reg_wdata[BW_AFC_LSB +: 8];
        end
        OFS_BITDIV: n.bitdiv = reg_wdata[15:0];
        OFS_STATUS: if (reg_wdata[ST_TIMEOUT]) n.to_flag = 1'b0;
        default: ;
      endcase
    end

    // Mode sequencer
    if (r.st != tgt) begin
      if (r.seq_dis) begin
        n.st = tgt;
      end else begin
        unique case (r.st)
          S_SLEEP: n.st = S_STBY;
          S_STBY: begin
            if (tgt == S_SLEEP || tgt == S_LISTEN) n.st = tgt;
            else if (r.sync2[SY_XO]) n.st = S_FS;
          end
          S_FS: begin
            if (!(tgt inside {S_TX, S_RX})) n.st = tgt;
            else if (r.sync2[SY_PLL]) n.st = (tgt == S_TX) ? S_TXREG : S_RX;
          end
          S_TXREG: begin
            if (tgt != S_TX) n.st = fall;
            else if (r.sync2[SY_PAREG]) n.st = S_TXRAMP;
          end
          S_TXRAMP: begin
            if (tgt != S_TX) n.st = fall;
            else if (r.sync2[SY_RAMP]) n.st = S_TX;
          end
          S_TX, S_RX, S_LISTEN: n.st = fall;
          default: n.st = S_SLEEP;
        endcase
      end
    end
    n.en = en_of(n.st);
    n.bclk = (n.st == S_TX) && (n.bitcnt < {1'b0, r.bitdiv[15:1]});

    // Frequency correction
    if (n.st != S_RX) begin
      n.afc_busy = 1'b0;
    end else if (!r.afc_busy) begin
      if ((r.st != S_RX && r.auto_on) || (r.st == S_RX && afc_cmd && !r.auto_on)) begin
        n.afc_busy = 1'b1;
        n.afc_bits = 3'h0;
        n.afc_pass = 1'b0;
        n.afc_relock = 1'b0;
        n.fei_go = 1'b1;
        // Without auto-clear the correction keeps accumulating from the corrected carrier
        if (r.auto_on && r.auto_clr) begin
          n.frf = r.frf + FW'($signed(r.afcval));
          n.afcval = 16'h0000;
        end
      end
    end else if (r.afc_relock) begin
      if (tick && r.sync2[SY_PLL]) begin
        if (r.lowix && !r.afc_pass) begin
          n.afc_pass = 1'b1;
          n.afc_bits = 3'h0;
          n.afc_relock = 1'b0;
          n.fei_go = 1'b1;
        end else begin
          n.afc_busy = 1'b0;
        end
      end
    end else if (tick) begin
      if (r.afc_bits == 3'(FEI_BITS - 1)) begin
        n.freq_error_indicator = measured_freq_error;
        n.frf = r.frf - FW'($signed(corr));
        n.afcval = r.afcval + corr;
        n.afc_relock = 1'b1;
      end else begin
        n.afc_bits = r.afc_bits + 3'h1;
      end
    end
    n.bw_sel = n.afc_busy ? n.bw_afc : n.bw_rx;

    // Temperature measurement
    if (!r.temp_run) begin
      if (reg_wr && reg_addr == OFS_TEMP && reg_wdata[TEMP_START] && (r.st == S_STBY || r.st == S_FS)) begin
        n.temp_run = 1'b1;
        n.temp_cnt = '0;
      end
    end else if (temp_done_in) begin
      n.temp_val = TEMP_ZERO - temp_celsius_in;
      n.temp_run = 1'b0;
    end else if (r.temp_cnt == TW'(TEMP_CYC - 1)) begin
      n.temp_run = 1'b0;
    end else begin
      n.temp_cnt = r.temp_cnt + 1'b1;
    end

    // Receive timeout
    if (n.st != S_RX || r.st != S_RX) begin
      n.rssi_seen = 1'b0;
      n.sub16 = 4'h0;
      n.units = 8'h00;
    end else if (r.sync2[SY_RSSI] && !r.rssi_seen) begin
      n.rssi_seen = 1'b1;
      n.sub16 = 4'h0;
      n.units = 8'h00;
    end else if (tick && lim != 8'h00 && r.units != lim) begin
      n.sub16 = r.sub16 + 4'h1;
      if (r.sub16 == 4'hF) begin
        n.units = r.units + 8'h01;
        if (r.units + 8'h01 == lim) n.to_flag = 1'b1;
      end
    end
  end

  always_comb begin
    rd = 32'h00000000;
    case (reg_addr)
      OFS_OPMODE: begin
        rd[OP_MODE_LSB +: 3] = r.mode;
        rd[OP_SEQDIS] = r.seq_dis;
        rd[OP_LISTEN] = r.listen;
      end
      OFS_AFC: begin
        rd[AFC_AUTO] = r.auto_on;
        rd[AFC_CLR] = r.auto_clr;
        rd[AFC_LOWIX] = r.lowix;
        rd[AFC_BUSY] = r.afc_busy;
      end
      OFS_LOWOFS: rd[7:0] = r.lowofs;
      OFS_FRF: rd[FW-1:0] = r.frf;
      OFS_AFCVAL: rd[15:0] = r.afcval;
      OFS_FEI: rd[15:0] = r.freq_error_indicator;
      OFS_TEMP: begin
        rd[TEMP_RUN] = r.temp_run;
        rd[TEMP_VAL_LSB +: 8] = r.temp_val;
      end
      OFS_TIMEOUT: begin
        rd[TO_START_LSB +: 8] = r.to_start;
        rd[TO_THR_LSB +: 8] = r.to_thr;
      end
      OFS_BW: begin
        rd[BW_RX_LSB +: 8] = r.bw_rx;
        rd[BW_AFC_LSB +: 8] = r.bw_afc;
      end
      OFS_BITDIV: rd[15:0] = r.bitdiv;
      OFS_STATUS: begin
        rd[ST_MODE_RDY] = mode_ready_irq;
        rd[ST_TX_RDY] = transmit_ready_irq;
        rd[ST_TIMEOUT] = r.to_flag;
        rd[ST_LOCK] = r.sync2[SY_PLL];
        rd[ST_STATE_LSB +: 4] = r.st;
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= RST;
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign xo_en = r.en[EN_XO];
  assign synth_en = r.en[EN_SYN];
  assign pa_reg_en = r.en[EN_PAREG];
  assign pa_ramp_en = r.en[EN_RAMP];
  assign tx_en = r.en[EN_TX];
  assign rx_en = r.en[EN_RX];
  assign listen_active = r.en[EN_LST];
  assign temp_adc_en = r.temp_run;
  assign fei_start = r.fei_go;
  assign bit_clock_output = r.bclk;
  assign pll_lock_out = r.sync2[SY_PLL];
  assign mode_ready_irq = (r.st == tgt);
  assign transmit_ready_irq = (r.st == S_TX);
  assign timeout_irq = r.to_flag;
  assign rx_bw_sel = r.bw_sel;
  assign frf_out = r.frf;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence ramp_step_s;
    r.st == S_TXRAMP ##1 r.st == S_TX;
  endsequence
  sequence reg_step_s;
    r.st == S_FS ##1 r.st == S_TXREG;
  endsequence

  afc_bw_sel_a: assert property (r.afc_busy |-> r.bw_sel == r.bw_afc)
    else $error("correction bandwidth not applied");
  afc_frf_sub_a: assert property (r.afc_busy && !r.afc_relock && tick && clk_en && n.st == S_RX
      && r.afc_bits == 3'(FEI_BITS - 1) |=> r.frf == $past(r.frf) - FW'($signed($past(corr))))
    else $error("carrier not corrected");
  auto_launch_a: assert property ($rose(r.st == S_RX) && $past(r.auto_on) |-> r.afc_busy && r.fei_go)
    else $error("auto correction missing");
  manual_afc_a: assert property ($rose(r.afc_busy) && !$past(r.auto_on) |-> $past(afc_cmd))
    else $error("correction without start bit");
  afc_clear_a: assert property ($rose(r.afc_busy) && $past(r.auto_on)
      |-> r.afcval == ($past(r.auto_clr) ? 16'h0000 : $past(r.afcval)))
    else $error("correction value not handled at launch");
  fei_bits_a: assert property ($rose(r.afc_relock) |-> $past(r.afc_bits) == 3'(FEI_BITS - 1))
    else $error("measurement length wrong");
  low_two_a: assert property ($fell(r.afc_busy) && r.st == S_RX && $past(r.lowix) |-> $past(r.afc_pass))
    else $error("low index single pass");
  tx_ramp_a: assert property (ramp_step_s |-> $past(r.sync2[SY_RAMP]) || $past(r.seq_dis, 2))
    else $error("transmit before ramp");
  tx_lock_a: assert property (reg_step_s |-> $past(r.sync2[SY_PLL]) || $past(r.seq_dis, 2))
    else $error("transmit path before lock");
  bclk_pa_a: assert property (r.bclk |-> r.en[EN_PAREG] && r.en[EN_RAMP])
    else $error("bit clock before amplifier");
  temp_mode_a: assert property ($rose(r.temp_run) |-> $past(r.st) inside {S_STBY, S_FS})
    else $error("temperature start in wrong mode");
  temp_bound_a: assert property (r.temp_run |-> r.temp_cnt < TW'(TEMP_CYC))
    else $error("temperature run too long");
  temp_value_a: assert property ($fell(r.temp_run) && $past(temp_done_in)
      |-> r.temp_val == TEMP_ZERO - $past(temp_celsius_in))
    else $error("temperature code wrong");
  start_to_a: assert property ($rose(r.to_flag) && !r.rssi_seen |-> r.units == r.to_start)
    else $error("start timeout count wrong");
  thr_to_a: assert property ($rose(r.to_flag) && r.rssi_seen |-> r.units == r.to_thr)
    else $error("threshold timeout count wrong");
  rx_stop_a: assert property (r.st != S_RX |-> r.units == 8'h00 && r.sub16 == 4'h0)
    else $error("timeout counting outside receive");
  listen_a: assert property (r.listen && r.seq_dis && clk_en |=> r.st == S_LISTEN)
    else $error("listen not entered");
  mode_rx_a: assert property (r.seq_dis && !r.listen && r.mode == 3'h4 && clk_en |=> r.st == S_RX)
    else $error("receive mode not decoded");
endmodule

// ---- verif/rmsrx_afe_model.sv ----
// Stand-in for the analog front end: each ready or lock pin follows its
// enable after a settling delay. Assumes enables come from the sequencer.
module rmsrx_afe_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Settling speed
  input wire logic slow,
  // Block enables
  input wire logic xo_en,
  input wire logic synth_en,
  input wire logic pa_reg_en,
  input wire logic pa_ramp_en,
  input wire logic temp_adc_en,
  // Status pins
  output logic xo_ready_pin,
  output logic pll_lock_pin,
  output logic pa_reg_ready_pin,
  output logic pa_ramp_done_pin,
  output logic temp_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] en;
  logic [4:0] rdy;
  int cnt [5];
  assign en = {temp_adc_en, pa_ramp_en, pa_reg_en, synth_en, xo_en};
  // A dropped enable clears its pin at the next clock edge
  always @(posedge sys_clk or negedge reset_n) begin
    for (int i = 0; i < 5; i++) begin
      if (!reset_n || !en[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < 255) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      rdy[i] = cnt[i] >= (slow ? 20 : 2) + i;
    end
  end
  assign xo_ready_pin = rdy[0];
  assign pll_lock_pin = rdy[1];
  assign pa_reg_ready_pin = rdy[2];
  assign pa_ramp_done_pin = rdy[3];
  assign temp_done_in = rdy[4];
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench of the mode sequencer: register master, analog model,
// read results queued and compared in the cycle after each read.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rmsrx_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic slow = 1'b1;
  logic [5:0] reg_addr = 6'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic signal_threshold_flag = 1'b0;
  logic [15:0] measured_freq_error = 16'h0;
  logic [7:0] temp_celsius_in = 8'h0;
  logic [31:0] reg_rdata;
  logic [23:0] frf_out;
  logic [7:0] rx_bw_sel;
  logic xo_ready_pin, pll_lock_pin, pa_reg_ready_pin, pa_ramp_done_pin, temp_done_in;
  logic xo_en, synth_en, pa_reg_en, pa_ramp_en, tx_en, rx_en, listen_active, temp_adc_en, fei_start;
  logic bit_clock_output, pll_lock_out, mode_ready_irq, transmit_ready_irq, timeout_irq;
  logic rd_d = 1'b0;
  logic [31:0] rdq [$];
  int error_cnt = 0;
  int checked = 0;
  int fei_cnt = 0;
  int bad = 0;
  int seed = 82361;
  rmsrx_top #(.TEMP_CYC(50), .FW(24)) rmsrx_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xo_ready_pin(xo_ready_pin), .pll_lock_pin(pll_lock_pin), .pa_reg_ready_pin(pa_reg_ready_pin),
    .pa_ramp_done_pin(pa_ramp_done_pin), .signal_threshold_flag(signal_threshold_flag),
    .measured_freq_error(measured_freq_error), .temp_done_in(temp_done_in), .temp_celsius_in(temp_celsius_in),
    .xo_en(xo_en), .synth_en(synth_en), .pa_reg_en(pa_reg_en), .pa_ramp_en(pa_ramp_en), .tx_en(tx_en),
    .rx_en(rx_en), .listen_active(listen_active), .temp_adc_en(temp_adc_en), .fei_start(fei_start),
    .bit_clock_output(bit_clock_output), .pll_lock_out(pll_lock_out), .mode_ready_irq(mode_ready_irq),
    .transmit_ready_irq(transmit_ready_irq), .timeout_irq(timeout_irq), .rx_bw_sel(rx_bw_sel), .frf_out(frf_out));
  rmsrx_afe_model rmsrx_afe_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .xo_en(xo_en),
    .synth_en(synth_en), .pa_reg_en(pa_reg_en), .pa_ramp_en(pa_ramp_en), .temp_adc_en(temp_adc_en),
    .xo_ready_pin(xo_ready_pin), .pll_lock_pin(pll_lock_pin), .pa_reg_ready_pin(pa_reg_ready_pin),
    .pa_ramp_done_pin(pa_ramp_done_pin), .temp_done_in(temp_done_in));
  always #10 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (fei_start === 1'b1) fei_cnt <= fei_cnt + 1;
  end
  always @(negedge sys_clk) begin
    if (rd_d === 1'b1 && rdq.size() > 0) check(reg_rdata, rdq.pop_front());
    if (reset_n && ((tx_en && !pll_lock_out) || (bit_clock_output && !tx_en) || (synth_en && !xo_en)
        || (tx_en && !(pa_reg_en && pa_ramp_en)))) bad++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rdq.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic go(input logic [31:0] m);
    wr(OFS_OPMODE, m);
    cyc(1);
    for (int i = 0; i < 300 && mode_ready_irq !== 1'b1; i++) cyc(1);
    check(mode_ready_irq, 1'b1);
  endtask
  // Launches one correction run by the given write and waits for its end
  task automatic afc(input logic [5:0] a, input logic [31:0] d, input int passes);
    int c0;
    c0 = fei_cnt;
    wr(a, d);
    for (int i = 0; i < 300 && fei_cnt == c0; i++) cyc(1);
    cyc(2);
    check(rx_bw_sel, BW_AFC_RST);
    for (int i = 0; i < 900 && rx_bw_sel !== BW_RX_RST; i++) cyc(1);
    check(fei_cnt - c0, passes);
  endtask
  task automatic tmo(output int n);
    for (n = 0; n < 400 && timeout_irq !== 1'b1; n++) cyc(1);
  endtask
  logic [2:0] modes [5] = '{3'h0, 3'h3, 3'h1, 3'h2, 3'h4};
  logic [3:0] sts [5] = '{4'h0, 4'h5, 4'h1, 4'h2, 4'h6};
  logic [3:0] ens [5] = '{4'h0, 4'hE, 4'h8, 4'hC, 4'hD};
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    int n;
    int hi;
    logic [15:0] e;
    logic [7:0] t;
    logic [23:0] f;
    e = 16'($random(seed) & 255) + 16'h0001;
    t = 8'($random(seed) & 63);
    f = 24'h100000;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(OFS_OPMODE, 32'h1);
    rd(OFS_BITDIV, 32'h28B1);
    rd(OFS_BW, 32'h8B55);
    wr(6'h3C, 32'h5A);
    rd(6'h3C, 32'h0);
    wr(OFS_BITDIV, 32'h4);
    for (int k = 0; k < 5; k++) begin
      go(32'(modes[k]));
      cyc(30);
      check({xo_en, synth_en, tx_en, rx_en}, ens[k]);
      rd(OFS_STATUS, {20'h0, sts[k], 4'h0, modes[k] >= 3'h2, 1'b0, modes[k] == 3'h3, 1'b1});
      if (modes[k] == 3'h3) begin
        hi = 0;
        for (int i = 0; i < 16; i++) begin
          hi += int'(bit_clock_output);
          cyc(1);
        end
        check(hi, 8);
      end
    end
    go(32'h0);
    wr(OFS_OPMODE, 32'hC);
    cyc(2);
    check({rx_en, pll_lock_out}, 2'b10);
    go(32'h1);
    wr(OFS_OPMODE, 32'h13);
    for (int i = 0; i < 100 && listen_active !== 1'b1; i++) cyc(1);
    check({listen_active, tx_en}, 2'b10);
    go(32'h1);
    @(posedge sys_clk);
    temp_celsius_in <= t;
    wr(OFS_TEMP, 32'h1);
    for (n = 0; n < 6000 && (n < 3 || temp_adc_en === 1'b1); n++) cyc(1);
    check(n < TEMP_MAX_CYC, 1'b1);
    rd(OFS_TEMP, {16'h0, TEMP_ZERO - t, 8'h00});
    go(32'h3);
    wr(OFS_TEMP, 32'h1);
    cyc(3);
    check(temp_adc_en, 1'b0);
    @(posedge sys_clk);
    slow <= 1'b0;
    measured_freq_error <= e;
    wr(OFS_FRF, 32'(f));
    wr(OFS_AFC, 32'h1);
    go(32'h2);
    afc(OFS_OPMODE, 32'h4, 1);
    check(frf_out, f - 24'(e));
    rd(OFS_AFCVAL, 32'(e));
    go(32'h2);
    afc(OFS_OPMODE, 32'h4, 1);
    rd(OFS_AFCVAL, 32'(e) * 2);
    wr(OFS_AFC, 32'h0);
    afc(OFS_AFC, 32'h8, 1);
    check(frf_out, f - 24'(e) * 3);
    go(32'h2);
    wr(OFS_FRF, 32'(f));
    wr(OFS_LOWOFS, 32'h10);
    wr(OFS_AFC, 32'h7);
    n = (16 * LOW_IDX_HZ) / FSTEP_HZ;
    afc(OFS_OPMODE, 32'h4, 2);
    check(frf_out, f + 24'(e) - 24'(n));
    rd(OFS_AFCVAL, 32'(e) * 2 + 32'(n));
    wr(OFS_AFC, 32'h0);
    go(32'h2);
    wr(OFS_TIMEOUT, 32'h0102);
    wr(OFS_OPMODE, 32'h4);
    for (int i = 0; i < 300 && rx_en !== 1'b1; i++) cyc(1);
    tmo(n);
    check(n >= 120 && n <= 136, 1'b1);
    wr(OFS_STATUS, 32'h4);
    cyc(1);
    check(timeout_irq, 1'b0);
    go(32'h2);
    cyc(200);
    check(timeout_irq, 1'b0);
    wr(OFS_OPMODE, 32'h4);
    for (int i = 0; i < 300 && rx_en !== 1'b1; i++) cyc(1);
    cyc(10);
    @(posedge sys_clk);
    signal_threshold_flag <= 1'b1;
    tmo(n);
    check(n >= 58 && n <= 76, 1'b1);
    check(bad, 0);
    summarize();
  end
endmodule
